/* File: design/sac_pkg.sv */
package sac_pkg;
   // register byte offsets on the AXI4-Lite slave
   localparam logic [3:0] ADDR_CONTROL_ONE  = 4'h0;
   localparam logic [3:0] ADDR_CONTROL_TWO  = 4'h4;
   localparam logic [3:0] ADDR_RESULT_VALUE = 4'h8;
   localparam logic [3:0] ADDR_RESULT_STAT  = 4'hC;

   // control one field positions
   localparam int CH_LSB    = 0;
   localparam int GATE_BIT  = 4;
   localparam int MODE_LSB  = 5;
   localparam int START_BIT = 7;
   // control two field positions
   localparam int TIME_LSB   = 0;
   localparam int LADDER_BIT = 5;
   // result status field positions
   localparam int RES_LOW_LSB = 6;
   localparam int DONE_BIT    = 5;
   localparam int BUSY_BIT    = 4;

   // reset values of the control registers, axi response codes and highest channel code
   localparam logic [7:0] CTRL_ONE_RESET = 8'h10;
   localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
   localparam logic [1:0] AXI_OKAY       = 2'h0;
   localparam logic [1:0] AXI_SLVERR     = 2'h2;
   localparam logic [3:0] MAX_CHANNEL    = 4'h5;

   // conversion durations in high_freq_clock cycles
   localparam int CONV_CYC_000 = 39;
   localparam int CONV_CYC_010 = 78;
   localparam int CONV_CYC_011 = 156;
   localparam int CONV_CYC_100 = 312;
   localparam int CONV_CYC_101 = 624;
   localparam int CONV_CYC_110 = 1248;

   typedef enum logic [1:0] {
      SAC_MODE_OFF    = 2'h0,
      SAC_MODE_SINGLE = 2'h1,
      SAC_MODE_RSVD   = 2'h2,
      SAC_MODE_REPEAT = 2'h3
   } sac_mode_t;

   typedef enum logic [1:0] {SAC_IDLE, SAC_CONVERT} sac_phase_t;

   // analog front end handshake toward the comparator and dac
   typedef struct packed {
      logic [3:0] channel;
      logic       inputs_enabled;
      logic       ladder_on;
      logic       sample;
      logic [9:0] trial_code;
   } sac_analog_t;

   // whole state of the controller
   typedef struct packed {
      sac_phase_t  phase;
      logic [7:0]  ctrl_one;
      logic [7:0]  ctrl_two;
      logic [9:0]  result;
      logic        done;
      logic        busy;
      logic [9:0]  trial;
      logic [3:0]  bit_idx;
      logic [10:0] step_cnt;
      logic [10:0] step_len;
      logic [10:0] total_cnt;
      logic        awhs;
      logic        whs;
      logic [3:0]  waddr;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        irq;
   } sac_state_t;
endpackage : sac_pkg

/* File: design/sac_adc_ctrl.sv */
`timescale 1ns/1ns
// Operation
// - convert the selected analog input into a 10-bit result by successive approximation
// - mode field: 00 off, 01 single start, 10 reserved, 11 repeat
// - channel codes 0 to 5 pick inputs zero to five, others reserved
// - gate bit 0 enables analog inputs, 1 disables; set 1 when unused
// - writing start trigger begins conversion; trigger self-clears once started
// - standby entry resets both control registers; writes ignored until normal
// - time field selects 39 to 1248 cycle conversion; 001 and 111 reserved
// - second control register holds the ladder network connect bit
// - bits 6 and 7 of control two read undefined
// - result value register holds data; status register holds busy and done
// - on completion store result, set done flag, pulse done interrupt
// - repeat mode restarts conversion right after each completion
// - writing mode 00 stops at once and discards partial result
// - reading result clears done flag; old result kept until new completes; standby zeroes it here
module sac_adc_ctrl
   import sac_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // power mode: high while the chip is in stop, slow or sleep
   input  wire logic        standby,
   // axi4-lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // analog front end
   input  wire logic        comparator_high,
   output sac_analog_t      analog,
   // conversion done interrupt pulse
   output logic             conversion_done_irq
);

   sac_state_t st;
   sac_state_t next_st;

   // cycles per conversion for a time code, zero for reserved codes
   // time code decode
   function automatic logic [10:0] conv_cycles(input logic [2:0] code);
      case (code)
         3'h0:    conv_cycles = 11'(CONV_CYC_000);
         3'h2:    conv_cycles = 11'(CONV_CYC_010);
         3'h3:    conv_cycles = 11'(CONV_CYC_011);
         3'h4:    conv_cycles = 11'(CONV_CYC_100);
         3'h5:    conv_cycles = 11'(CONV_CYC_101);
         3'h6:    conv_cycles = 11'(CONV_CYC_110);
         default: conv_cycles = 11'h000;
      endcase
   endfunction : conv_cycles

   logic        aw_take;
   logic        w_take;
   logic        ar_take;
   logic        do_write;
   logic [1:0]  mode;
   logic [2:0]  tcode;
   logic        ch_ok;
   logic        kick;
   logic [10:0] per_bit;

   // one write and one read at a time; the address and data are taken separately
   assign s_axi_awready = !st.awhs && !st.bvalid;
   assign s_axi_wready  = !st.whs && !st.bvalid;
   assign s_axi_arready = !st.rvalid;
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign ar_take       = s_axi_arvalid && s_axi_arready;

   // response and interrupt outputs come straight from flip-flops
   assign s_axi_bvalid        = st.bvalid;
   assign s_axi_bresp         = st.bresp;
   assign s_axi_rvalid        = st.rvalid;
   assign s_axi_rdata         = st.rdata;
   assign s_axi_rresp         = st.rresp;
   assign conversion_done_irq = st.irq;
   assign tcode               = st.ctrl_two[TIME_LSB +: 3];

   // front end drive
   always_comb
   begin
      analog.channel        = st.ctrl_one[CH_LSB +: 4];
      analog.inputs_enabled = !st.ctrl_one[GATE_BIT];
      analog.ladder_on      = st.ctrl_two[LADDER_BIT];
      analog.sample         = (st.phase == SAC_CONVERT);
      analog.trial_code     = st.trial;
   end

   // next state
   always_comb
   begin
      next_st  = st;
      next_st.irq = 1'b0;
      do_write = 1'b0;
      ch_ok    = 1'b0;
      mode     = 2'h0;
      kick     = 1'b0;
      per_bit  = 11'h000;

      // capture address and data in either order
      if (aw_take)
      begin
         next_st.awhs  = 1'b1;
         next_st.waddr = s_axi_awaddr;
      end
      if (w_take)
      begin
         next_st.whs    = 1'b1;
         next_st.wdata  = s_axi_wdata[7:0];
         next_st.wstrb0 = s_axi_wstrb[0];
      end
      if (next_st.awhs && next_st.whs && !st.bvalid)
      begin
         do_write       = 1'b1;
         next_st.awhs   = 1'b0;
         next_st.whs    = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = (next_st.waddr[3:2] == ADDR_CONTROL_ONE[3:2]
                           || next_st.waddr[3:2] == ADDR_CONTROL_TWO[3:2]) ? AXI_OKAY
                                                                          : AXI_SLVERR;
      end
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;

      // register writes, dropped while in standby
      if (do_write && next_st.wstrb0 && !standby)
      begin
         if (next_st.waddr[3:2] == ADDR_CONTROL_ONE[3:2])
            next_st.ctrl_one = next_st.wdata;
         else if (next_st.waddr[3:2] == ADDR_CONTROL_TWO[3:2])
            next_st.ctrl_two = next_st.wdata;
      end

      // register reads
      if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
      if (ar_take)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = AXI_OKAY;
         next_st.rdata  = 32'h0000_0000;
         case (s_axi_araddr[3:2])
            ADDR_CONTROL_ONE[3:2]:
               next_st.rdata[7:0] = st.ctrl_one;
            ADDR_CONTROL_TWO[3:2]:
               // upper bits undefined, read as zero
               next_st.rdata[5:0] = st.ctrl_two[5:0];
            ADDR_RESULT_VALUE[3:2]:
            begin
               next_st.rdata[7:0] = st.result[9:2];
               next_st.done       = 1'b0;
            end
            ADDR_RESULT_STAT[3:2]:
            begin
               // status flags beside low result bits
               next_st.rdata[RES_LOW_LSB +: 2] = st.result[1:0];
               next_st.rdata[DONE_BIT]         = st.done;
               next_st.rdata[BUSY_BIT]         = st.busy;
            end
            default:
               next_st.rresp = AXI_SLVERR;
         endcase
      end

      // decode from the value just written, so a start and its mode land together
      mode    = next_st.ctrl_one[MODE_LSB +: 2];
      ch_ok   = (next_st.ctrl_one[CH_LSB +: 4] <= MAX_CHANNEL);
      // per step duration, ten decisions fit the total
      // leftover cycles after the tenth step only re-check bit zero
      per_bit = conv_cycles(tcode) / 11'h00A;

      // sequencer
      case (st.phase)
         SAC_IDLE:
         begin
            // only single and repeat modes run
            if (next_st.ctrl_one[START_BIT] && ch_ok && per_bit != 11'h000
                && (mode == SAC_MODE_SINGLE || mode == SAC_MODE_REPEAT))
               kick = 1'b1;
            next_st.ctrl_one[START_BIT] = 1'b0;
         end
         SAC_CONVERT:
         begin
            next_st.step_cnt  = st.step_cnt + 11'h001;
            next_st.total_cnt = st.total_cnt + 11'h001;
            if (st.step_cnt == st.step_len - 11'h001)
            begin
               next_st.step_cnt = 11'h000;
               if (!comparator_high)
                  next_st.trial[st.bit_idx] = 1'b0;
               if (st.bit_idx != 4'h0)
               begin
                  next_st.bit_idx = st.bit_idx - 4'h1;
                  next_st.trial[st.bit_idx - 4'h1] = 1'b1;
               end
            end
            if (st.total_cnt == conv_cycles(tcode) - 11'h001)
            begin
               next_st.result = next_st.trial;
               next_st.done   = 1'b1;
               next_st.irq    = 1'b1;
               next_st.busy   = 1'b0;
               next_st.phase  = SAC_IDLE;
               if (mode == SAC_MODE_REPEAT && ch_ok)
                  kick = 1'b1;
            end
            if (next_st.ctrl_one[MODE_LSB +: 2] == SAC_MODE_OFF)
            begin
               next_st.phase = SAC_IDLE;
               next_st.busy  = 1'b0;
               next_st.done  = st.done && !(ar_take
                               && s_axi_araddr[3:2] == ADDR_RESULT_VALUE[3:2]);
               next_st.irq   = 1'b0;
               kick          = 1'b0;
            end
            // a stray trigger mid-conversion is dropped
            next_st.ctrl_one[START_BIT] = 1'b0;
         end
         default:
            next_st.phase = SAC_IDLE;
      endcase

      if (kick)
      begin
         next_st.phase     = SAC_CONVERT;
         next_st.busy      = 1'b1;
         // restart clears done, old result stays
         // a repeat restart keeps the done just set: the set wins
         if (st.phase == SAC_IDLE)
            next_st.done   = 1'b0;
         next_st.trial     = 10'h200;
         next_st.bit_idx   = 4'h9;
         next_st.step_cnt  = 11'h000;
         next_st.total_cnt = 11'h000;
         next_st.step_len  = per_bit;
      end

      // standby resets controls and kills conversion, result lost
      if (standby)
      begin
         next_st.ctrl_one = CTRL_ONE_RESET;
         next_st.ctrl_two = CTRL_TWO_RESET;
         next_st.phase    = SAC_IDLE;
         next_st.busy     = 1'b0;
         next_st.done     = 1'b0;
         next_st.result   = 10'h000;
         next_st.irq      = 1'b0;
      end
   end

   // state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st          <= '0;
         st.phase    <= SAC_IDLE;
         st.ctrl_one <= CTRL_ONE_RESET;
         st.ctrl_two <= CTRL_TWO_RESET;
      end
      else
         st <= next_st;
   end

endmodule : sac_adc_ctrl

/* File: sim/sac_comparator_model.sv */
`timescale 1ns/1ns
module sac_comparator_model
   import sac_pkg::*;
(
   // clock
   input  wire logic        aclk,
   // controller side
   input  wire sac_analog_t analog,
   input  wire logic [9:0]  level,
   // comparator answer
   output logic             comparator_high
);
   logic flip;

   // no decision outside sampling, so toggle to expose stale use
   always @(posedge aclk)
      flip <= (flip === 1'b0);

   assign comparator_high = analog.sample ? (level >= analog.trial_code) : flip;
endmodule : sac_comparator_model

/* File: sim/sac_adc_ctrl_checker.sv */
`timescale 1ns/1ns
module sac_adc_ctrl_checker
   import sac_pkg::*;
(
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // watched ports
   input wire logic        standby,
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rready,
   input wire logic        s_axi_arready,
   input wire sac_analog_t analog,
   input wire logic        conversion_done_irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // a conversion begins, then keeps sampling for its first eight cycles
   sequence s_start;
      $rose(analog.sample);
   endsequence
   sequence s_deciding;
      analog.sample[*8];
   endsequence

   a_irq_pulse: assert property (conversion_done_irq |=> !conversion_done_irq)
      else $error("done pulse longer than one cycle");
   a_irq_cause: assert property (conversion_done_irq |-> $past(analog.sample))
      else $error("done pulse without a running conversion");
   a_first_trial: assert property (s_start |-> analog.trial_code == 10'h200)
      else $error("first trial is not the top bit");
   a_busy_span: assert property (s_start |-> s_deciding)
      else $error("conversion ended too early");
   a_standby_stop: assert property (standby |=> !analog.sample && !analog.inputs_enabled)
      else $error("standby did not stop and gate");
   a_ro_write: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_awaddr == ADDR_RESULT_VALUE |-> ##[1:3] s_axi_bresp == AXI_SLVERR)
      else $error("result write not refused");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before taken");
endmodule : sac_adc_ctrl_checker

/* File: sim/sac_adc_ctrl_test.sv */
`timescale 1ns/1ns
module sac_adc_ctrl_test;
   import sac_pkg::*;
   logic        aclk, aresetn, standby, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, cmp_hi, irq;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val;
   logic [1:0]  bresp, rresp, resp;
   logic [9:0]  level;
   sac_analog_t analog;
   int          n_mismatch, compares, run, last_len, n_irq;

   // clock at 250 MHz
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   sac_adc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .standby(standby),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .comparator_high(cmp_hi), .analog(analog),
      .conversion_done_irq(irq));
   sac_comparator_model i_cmp (.aclk(aclk), .analog(analog), .level(level),
      .comparator_high(cmp_hi));

   // cycles from sampling start to done pulse; restart counts as cycle one
   always @(posedge aclk)
   begin
      run <= analog.sample ? (irq ? 1 : run + 1) : 0;
      if (irq) last_len <= run;
      if (irq) n_irq <= n_irq + 1;
   end

   task stop_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wait_edge(input int n, ref logic sig);
      int i;
      for (i = 0; i < n; i++)
      begin
         @(posedge aclk);
         if (sig === 1'b1) break;
      end
      if (i == n)
      begin
         n_mismatch++;
         stop_test;
      end
   endtask : wait_edge

   // write both halves together, drop each once taken
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      fork
         begin
            wait_edge(200, awready);
            awvalid <= 1'b0;
         end
         begin
            wait_edge(200, wready);
            wvalid <= 1'b0;
         end
      join
      if (!bvalid) wait_edge(200, bvalid);
      resp   = bresp;
      bready <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      wait_edge(200, arready);
      arvalid <= 1'b0;
      if (!rvalid) wait_edge(200, rvalid);
      rd_val = rdata;
      rready <= 1'b0;
   endtask : rd

   task t_reset;
      logic [7:0] exp[4] = '{CTRL_ONE_RESET, CTRL_TWO_RESET, 8'h00, 8'h00};
      for (int i = 0; i < 4; i++)
      begin
         rd(4'(i * 4));
         chk(rd_val, exp[i]);
      end
      wr(ADDR_RESULT_VALUE, 8'hFF);
      chk(resp, AXI_SLVERR);
      $display("reset test done");
   endtask : t_reset

   task t_single;
      // only codes allowed at this clock
      logic [2:0] code[2] = '{3'h0, 3'h2};
      int         len[2]  = '{CONV_CYC_000, CONV_CYC_010};
      for (int i = 0; i < 2; i++)
      begin
         level <= 10'h2C5 + 10'(i);
         // ladder on, bit4 high, bit0 low
         wr(ADDR_CONTROL_TWO, {3'b011, 2'b10, code[i]});
         wr(ADDR_CONTROL_ONE, 8'hA3);
         chk({analog.channel, analog.inputs_enabled, analog.ladder_on}, 6'h0F);
         // no restart or channel change before done
         wait_edge(2000, irq);
         @(posedge aclk);
         chk(last_len, len[i]);
         rd(ADDR_RESULT_STAT);
         chk(rd_val[7:4], {level[1:0], 2'b10});
         rd(ADDR_CONTROL_ONE);
         chk(rd_val, 8'h23);
         rd(ADDR_RESULT_VALUE);
         chk(rd_val, level[9:2]);
         rd(ADDR_RESULT_STAT);
         chk(rd_val[5], 1'b0);
      end
      $display("single test done");
   endtask : t_single

   task t_refused;
      logic [7:0] cmd[3] = '{8'h83, 8'hC3, 8'hA6};
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR_CONTROL_ONE, cmd[i]);
         repeat (4) @(posedge aclk);
         chk(analog.sample, 1'b0);
      end
      $display("refused start test done");
   endtask : t_refused

   task t_repeat;
      int seen;
      wr(ADDR_CONTROL_TWO, 8'h30);
      wr(ADDR_CONTROL_ONE, 8'hE1);
      wait_edge(2000, irq);
      wait_edge(2000, irq);
      @(posedge aclk);
      chk(last_len, CONV_CYC_000);
      chk(analog.sample, 1'b1);
      rd(ADDR_RESULT_STAT);
      chk(rd_val[5:4], 2'b11);
      level <= 10'h155;
      repeat (10) @(posedge aclk);
      seen = n_irq;
      wr(ADDR_CONTROL_ONE, 8'h01);
      repeat (60) @(posedge aclk);
      chk(analog.sample, 1'b0);
      chk(n_irq, seen);
      rd(ADDR_RESULT_VALUE);
      chk(rd_val, 8'hB1);
      $display("repeat test done");
   endtask : t_repeat

   task t_standby;
      wr(ADDR_CONTROL_ONE, 8'h22);
      standby <= 1'b1;
      wr(ADDR_CONTROL_ONE, 8'h25);
      rd(ADDR_CONTROL_ONE);
      chk(rd_val, CTRL_ONE_RESET);
      rd(ADDR_CONTROL_TWO);
      chk(rd_val, CTRL_TWO_RESET);
      standby <= 1'b0;
      $display("standby test done");
   endtask : t_standby

   // main sequence
   initial
   begin
      {aresetn, standby, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata  = 32'h0;
      level  = 10'h2C5;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_single;
      t_refused;
      t_repeat;
      t_standby;
      stop_test;
   end
endmodule : sac_adc_ctrl_test

bind sac_adc_ctrl sac_adc_ctrl_checker i_chk (.aclk(aclk), .aresetn(aresetn),
   .standby(standby), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rready(s_axi_rready),
   .s_axi_arready(s_axi_arready),
   .analog(analog), .conversion_done_irq(conversion_done_irq));
